// >>> hdl/pff_pkg.sv
// Summary of operation
// (R1) Client dropping its request sends an XON after the current frame ends.
// (R2) Software clearing a bit of the pause request register also sends an XON.
// (R3) Rising request level sends one XOFF when that class's transmit pause enable is set.
// (R4) With retransmission on, XOFF repeats each hold-off period while requested.
// (R5) An address-matched received pause sets the pause match output bit of its queue.
// (R6) Request and match vectors are N wide; standard flow control has N of one.
// (R7) Processing disabled stops received pauses touching transmit; enabled after reset.
// (R8) Enabled processing compares destination against the 48-bit programmed address.
// (R9) The programmed address may be individual, multicast or broadcast.
// (R10) Standard mode TX ignores RX pause while honour bit is 0; resets to 1.
// (R11) Pass-through bit controls forwarding of matched pauses; off after reset.
// (R12) Non-matching pause frames always reach the RX client.
// (R13) Processing disabled drops matching pause frames with type 8808, opcode 1.
// (R14) Enabled and matched, each received pause raises a request to TX.
// (R15) Only pauses to the pause multicast or programmed address are acted upon.
// (R16) Matched pause reaches the client only with pass-through on.
// (R17) PFC, or standard with honour set, holds TX off on an RX pause request.
// (R18) Pass-through never changes pause behaviour on either side.
// (R19) Pass-through decision applies equally to runt and bad FCS pauses.
// (R20) Strict variant never processes standard runt or bad FCS pauses.
// (R21) Pause time counts in quanta of 512 bit times.
// (R22) Rising request sends XOFF once the current frame transmission completes.
// (R23) Pause match bits stay high while the received pause period runs.
package pff_pkg;
    localparam int NQ_PFC = 8;
    localparam int ADDR_W = 14;
    localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
    localparam logic [15:0] OPC_STD = 16'h0001;
    localparam logic [15:0] OPC_PFC = 16'h0101;
    localparam logic [47:0] PAUSE_MCAST = 48'h0180C2000001;
    localparam logic [11:0] IDX_CTRL = 12'h700;
    localparam logic [11:0] IDX_TXEN = 12'h701;
    localparam logic [11:0] IDX_SWREQ = 12'h702;
    localparam logic [11:0] IDX_HOLDOFF = 12'h703;
    localparam logic [11:0] IDX_STATUS = 12'h704;
    localparam logic [11:0] IDX_ADDR_LO = 12'h707;
    localparam logic [11:0] IDX_ADDR_HI = 12'h708;
    localparam int CTRL_PROC_BIT = 0;
    localparam int CTRL_FWD_BIT = 1;
    localparam int CTRL_HONOUR_BIT = 2;
    localparam int CTRL_RETX_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h5;
    localparam logic [7:0] TXEN_RESET = 8'hFF;
    localparam logic [7:0] SWREQ_RESET = 8'h00;
    localparam logic [15:0] HOLDOFF_RESET = 16'h00FF;
    localparam logic [31:0] ADDR_LO_RESET = 32'h00000000;
    localparam logic [15:0] ADDR_HI_RESET = 16'h0000;
    localparam int QUANTUM_BITS = 512;
    localparam int LINK_GBPS = 40;
    localparam int QUANTUM_PS = QUANTUM_BITS * 1000 / LINK_GBPS;
    localparam int CLK_PS = 10000;
    localparam int QUANTUM_CYCLES = (QUANTUM_PS + CLK_PS - 1) / CLK_PS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [47:0] da;
        logic [15:0] ethertype;
        logic [15:0] opcode;
        logic [7:0] prio_en;
        logic [15:0] quanta;
        logic bad;
    } pff_rx_desc_t;

    typedef struct packed {
        logic xon;
        logic [2:0] cls;
    } pff_tx_cmd_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SEND = 2'b10
    } pff_txst_t;
endpackage

// >>> hdl/pff_quanta_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pff_quanta_timer
    import pff_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic load,
    input wire logic [15:0] load_value,
    output logic running,
    output logic expired
);
    logic [15:0] count;

    // A fresh load overrides whatever remains, so the last quanta received wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (load) begin
            count <= load_value;
            running <= (load_value != 16'h0000);
            expired <= 1'b0;
        end else if (tick && count != 16'h0000) begin
            count <= count - 16'h0001;
            running <= (count != 16'h0001);
            expired <= (count == 16'h0001);
        end else begin
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/pff_pause_filter.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pff_pause_filter
    import pff_pkg::*;
#(
    parameter bit PFC_MODE = 1'b0,
    parameter bit STRICT_BAD_DROP = 1'b0,
    localparam int NQ = PFC_MODE ? NQ_PFC : 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NQ-1:0] pause_request_in,
    input wire logic tx_frame_busy,
    output pff_tx_cmd_t tx_cmd,
    output logic tx_cmd_valid,
    input wire logic tx_cmd_ready,
    input wire pff_rx_desc_t rx_desc,
    input wire logic rx_desc_valid,
    output logic rx_verdict_valid,
    output logic rx_verdict_deliver,
    output logic [NQ-1:0] pause_match_out,
    output logic [NQ-1:0] tx_pause_hold
);
    function automatic logic [11:0] addr_idx(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [11:0] idx);
        return idx == IDX_CTRL || idx == IDX_TXEN || idx == IDX_SWREQ ||
               idx == IDX_HOLDOFF || idx == IDX_STATUS ||
               idx == IDX_ADDR_LO || idx == IDX_ADDR_HI;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [3:0] ctrl;
    logic [7:0] tx_pause_en;
    logic [7:0] sw_req;
    logic [15:0] holdoff;
    logic [31:0] addr_lo;
    logic [15:0] addr_hi;

    logic aw_held;
    logic w_held;
    logic [11:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;

    logic proc_en;
    logic fwd_en;
    logic honour;
    logic retx_en;

    assign proc_en = ctrl[CTRL_PROC_BIT];
    assign fwd_en = ctrl[CTRL_FWD_BIT];
    assign honour = ctrl[CTRL_HONOUR_BIT];
    assign retx_en = ctrl[CTRL_RETX_BIT];

    // Address and data are taken independently; the write lands once both are held.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx <= addr_idx(s_axi_awaddr);
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET; // (R7) (R10) (R11)
            tx_pause_en <= TXEN_RESET;
            sw_req <= SWREQ_RESET;
            holdoff <= HOLDOFF_RESET;
            addr_lo <= ADDR_LO_RESET;
            addr_hi <= ADDR_HI_RESET;
        end else if (wr_fire) begin
            unique case (aw_idx)
                IDX_CTRL: ctrl <= 4'(merge(32'(ctrl), w_data, w_strb));
                IDX_TXEN: tx_pause_en <= 8'(merge(32'(tx_pause_en), w_data, w_strb));
                IDX_SWREQ: sw_req <= 8'(merge(32'(sw_req), w_data, w_strb));
                IDX_HOLDOFF: holdoff <= 16'(merge(32'(holdoff), w_data, w_strb));
                IDX_ADDR_LO: addr_lo <= merge(addr_lo, w_data, w_strb); // (R8)
                IDX_ADDR_HI: addr_hi <= 16'(merge(32'(addr_hi), w_data, w_strb));
                default: ;
            endcase
        end
    end

    pff_txst_t tx_state;
    logic [NQ-1:0] req_prev;
    logic [NQ-1:0] pend_xoff;
    logic [NQ-1:0] pend_xon;
    logic [NQ-1:0] retx_expired;
    logic [NQ-1:0] rx_running;
    logic [2:0] cls_sel;
    logic sent;
    logic [3:0] qdiv;
    logic qtick;
    logic rx_is_pause;
    logic rx_addr_hit;
    logic rx_bad_block;
    logic rx_act;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(addr_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
            unique case (addr_idx(s_axi_araddr))
                IDX_CTRL: s_axi_rdata <= 32'(ctrl);
                IDX_TXEN: s_axi_rdata <= 32'(tx_pause_en);
                IDX_SWREQ: s_axi_rdata <= 32'(sw_req);
                IDX_HOLDOFF: s_axi_rdata <= 32'(holdoff);
                IDX_STATUS: s_axi_rdata <= {15'h0000, tx_state != TX_IDLE,
                                            8'(tx_pause_hold), 8'(pause_match_out)};
                IDX_ADDR_LO: s_axi_rdata <= addr_lo;
                IDX_ADDR_HI: s_axi_rdata <= 32'(addr_hi);
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // One quantum is a little over one clock at this rate, so it rounds up.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qdiv <= 4'h0;
        end else if (qdiv == 4'(QUANTUM_CYCLES - 1)) begin
            qdiv <= 4'h0;
        end else begin
            qdiv <= qdiv + 4'h1;
        end
    end
    assign qtick = (qdiv == 4'(QUANTUM_CYCLES - 1)); // (R21)

    // Pin and register requests combine, so either source can start a pause, but it stops only when both are clear.
    logic [NQ-1:0] req_now;
    assign req_now = pause_request_in | sw_req[NQ-1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_prev <= '0;
        end else begin
            req_prev <= req_now;
        end
    end

    assign sent = (tx_state == TX_SEND) && tx_cmd_ready;

    genvar n;
    generate
        for (n = 0; n < NQ; n++) begin : g_class
            logic set_xoff;
            logic set_xon;
            logic clr_xoff;
            logic clr_xon;
            logic mine;
            logic rx_load;

            assign mine = sent && (tx_cmd.cls == 3'(n));
            assign set_xoff = tx_pause_en[n] && ((req_now[n] && !req_prev[n]) || // (R3) (R22)
                              (retx_en && retx_expired[n] && req_now[n])); // (R4)
            assign set_xon = !req_now[n] && req_prev[n]; // (R1) (R2)
            assign clr_xoff = mine && !tx_cmd.xon;
            assign clr_xon = mine && tx_cmd.xon;

            // A new event beats the clear from a frame sent in the same cycle.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pend_xoff[n] <= 1'b0;
                    pend_xon[n] <= 1'b0;
                end else begin
                    if (set_xoff) begin
                        pend_xoff[n] <= 1'b1;
                    end else if (set_xon || clr_xoff) begin
                        pend_xoff[n] <= 1'b0;
                    end
                    if (set_xon) begin
                        pend_xon[n] <= 1'b1;
                    end else if (set_xoff || clr_xon) begin
                        pend_xon[n] <= 1'b0;
                    end
                end
            end

            pff_quanta_timer u_holdoff (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(qtick),
                .load(mine), // (R4)
                .load_value(tx_cmd.xon ? 16'h0000 : holdoff),
                .running(),
                .expired(retx_expired[n])
            );

            assign rx_load = rx_act && (PFC_MODE ? rx_desc.prio_en[n] : 1'b1);

            pff_quanta_timer u_rx_pause (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(qtick),
                .load(rx_load), // (R14) (R21)
                .load_value(rx_desc.quanta),
                .running(rx_running[n]),
                .expired()
            );
        end
    endgenerate

    // The class is fixed on entry, the XON or XOFF kind only when the link is free.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= TX_IDLE;
            cls_sel <= 3'h0;
            tx_cmd <= '0;
        end else begin
            unique case (tx_state)
                TX_IDLE: begin
                    if (|(pend_xoff | pend_xon)) begin
                        cls_sel <= first_set(8'(pend_xoff | pend_xon));
                        tx_state <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (!tx_frame_busy) begin // (R1) (R22)
                        tx_cmd.cls <= cls_sel;
                        tx_cmd.xon <= 1'(8'(pend_xon) >> cls_sel);
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_cmd_ready) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
    assign tx_cmd_valid = (tx_state == TX_SEND);

    assign rx_is_pause = rx_desc_valid && (rx_desc.ethertype == PAUSE_ETHERTYPE) &&
                         (rx_desc.opcode == (PFC_MODE ? OPC_PFC : OPC_STD)); // (R13)
    assign rx_addr_hit = (rx_desc.da == {addr_hi, addr_lo}) || // (R8) (R9)
                         (rx_desc.da == PAUSE_MCAST); // (R15)
    assign rx_bad_block = STRICT_BAD_DROP && !PFC_MODE && rx_desc.bad; // (R20)
    assign rx_act = rx_is_pause && rx_addr_hit && proc_en && !rx_bad_block; // (R7) (R14) (R18)

    // Delivery ignores the bad flag, so runts and bad FCS frames are judged alike.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_verdict_valid <= 1'b0;
            rx_verdict_deliver <= 1'b0;
        end else begin
            rx_verdict_valid <= rx_desc_valid;
            rx_verdict_deliver <= !(rx_is_pause && rx_addr_hit) || // (R12) (R13)
                                  (proc_en && fwd_en); // (R11) (R16) (R19)
        end
    end

    assign pause_match_out = rx_running; // (R5) (R6) (R23)

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pause_hold <= '0;
        end else begin
            tx_pause_hold <= rx_running & {NQ{PFC_MODE || honour}}; // (R10) (R17)
        end
    end
endmodule
`default_nettype wire

// >>> dv/pff_pause_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pff_pause_monitor
    import pff_pkg::*;
#(
    parameter int NQ = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic tx_frame_busy,
    input wire pff_tx_cmd_t tx_cmd,
    input wire logic tx_cmd_valid,
    input wire logic tx_cmd_ready,
    input wire pff_rx_desc_t rx_desc,
    input wire logic rx_desc_valid,
    input wire logic rx_verdict_valid,
    input wire logic rx_verdict_deliver,
    input wire logic [NQ-1:0] pause_match_out,
    input wire logic [NQ-1:0] tx_pause_hold
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_VERDICT_ONE: assert property (rx_desc_valid |=> rx_verdict_valid)
        else $error("verdict missing after descriptor");
    AST_VERDICT_NONE: assert property (!rx_desc_valid |=> !rx_verdict_valid)
        else $error("verdict without descriptor");
    AST_NONPAUSE_PASS: assert property (rx_desc_valid && rx_desc.ethertype != PAUSE_ETHERTYPE
        |=> rx_verdict_deliver)
        else $error("ordinary frame withheld");
    AST_MATCH_CAUSE: assert property ($rose(pause_match_out[0]) |-> $past(rx_desc_valid))
        else $error("match rose without a received frame");
    AST_HOLD_FROM_MATCH: assert property ($rose(tx_pause_hold[0]) |-> $past(pause_match_out[0]))
        else $error("transmit hold without match");
    AST_CMD_STANDS: assert property (tx_cmd_valid && !tx_cmd_ready
        |=> tx_cmd_valid && $stable(tx_cmd))
        else $error("command dropped or changed before acceptance");
    AST_CMD_AFTER_FRAME: assert property ($rose(tx_cmd_valid) |-> !$past(tx_frame_busy))
        else $error("command offered mid-frame");
    AST_CMD_GAP: assert property (tx_cmd_valid && tx_cmd_ready |=> !tx_cmd_valid)
        else $error("no idle cycle between commands");
    AST_BRESP_STANDS: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    cover property ($rose(pause_match_out[0]));
    cover property (tx_cmd_valid && tx_cmd_ready && tx_cmd.xon);
    cover property (rx_verdict_valid && !rx_verdict_deliver);
endmodule

bind pff_pause_filter pff_pause_monitor #(.NQ(NQ)) u_pff_pause_monitor (.aclk, .aresetn,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .tx_frame_busy, .tx_cmd, .tx_cmd_valid, .tx_cmd_ready, .rx_desc, .rx_desc_valid,
    .rx_verdict_valid, .rx_verdict_deliver, .pause_match_out, .tx_pause_hold);
`default_nettype wire

// >>> dv/pff_txmac_model.sv
`timescale 1ns/1ps
`default_nettype none
module pff_txmac_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_cmd_valid,
    output logic tx_frame_busy,
    output logic tx_cmd_ready
);
    int unsigned left;
    int unsigned wait_n;

    // Frames start at random so commands must often wait for a frame end.
    always @(posedge aclk) begin
        if (!aresetn) begin
            left <= 0;
            tx_frame_busy <= 1'h0;
            tx_cmd_ready <= 1'h0;
            wait_n <= 0;
        end else begin
            if (left != 0) begin
                left <= left - 1;
            end else if ($urandom_range(3) == 0) begin
                left <= $urandom_range(6, 1);
            end
            tx_frame_busy <= (left > 1) || (left == 0 && $urandom_range(3) == 0);
            if (tx_cmd_valid && !tx_cmd_ready) begin
                if (wait_n == 0) begin
                    tx_cmd_ready <= 1'h1;
                    wait_n <= $urandom_range(2);
                end else begin
                    wait_n <= wait_n - 1;
                end
            end else begin
                tx_cmd_ready <= 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import pff_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rx_desc_valid = 1'h0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_cmd_valid, tx_cmd_ready, tx_frame_busy, rx_verdict_valid, rx_verdict_deliver;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [0:0] pause_request_in = '0, pause_match_out, tx_pause_hold;
    pff_tx_cmd_t tx_cmd;
    pff_rx_desc_t rx_desc = '0;
    logic [33:0] vq[$], cq[$], rq[$], bq[$];
    int n_errors = 0, n_compared = 0, n_retx = 0;
    bit retx = 1'h0;
    logic [47:0] a;

    pff_pause_filter u_pff_pause_filter (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pause_request_in, .tx_frame_busy, .tx_cmd, .tx_cmd_valid, .tx_cmd_ready, .rx_desc,
        .rx_desc_valid, .rx_verdict_valid, .rx_verdict_deliver, .pause_match_out, .tx_pause_hold);
    pff_txmac_model u_pff_txmac_model (.aclk, .aresetn, .tx_cmd_valid, .tx_frame_busy,
        .tx_cmd_ready);

    always #5 aclk = ~aclk;

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task close_out;
        n_errors += vq.size() + cq.size() + rq.size() + bq.size();
        $display("Errors %0d, compares %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // An empty queue yields unknown, so any unexpected result is a mismatch.
    always @(posedge aclk) begin
        if (rx_verdict_valid) chk(34'(rx_verdict_deliver), vq.size() ? vq.pop_front() : 'x);
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), bq.size() ? bq.pop_front() : 'x);
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x);
        if (tx_cmd_valid && tx_cmd_ready) begin
            if (retx && !tx_cmd.xon) n_retx++;
            else chk(34'(tx_cmd), cq.size() ? cq.pop_front() : 'x);
        end
    end

    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        bq.push_back(34'(er));
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] idx, input logic [33:0] e);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        rq.push_back(e);
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask

    // Three quanta give a pause of six cycles, so match is seen high and then gone.
    task automatic rx(input logic [47:0] da, input logic [15:0] et, input logic [15:0] op,
                      input logic bad, input logic dl, input logic m, input logic h);
        @(posedge aclk);
        rx_desc <= {da, et, op, 8'($urandom), 16'h0003, bad};
        rx_desc_valid <= 1'h1;
        vq.push_back(34'(dl));
        @(posedge aclk);
        rx_desc_valid <= 1'h0;
        @(posedge aclk);
        chk(34'(pause_match_out), 34'(m));
        repeat (3) @(posedge aclk);
        chk(34'({pause_match_out, tx_pause_hold}), 34'({m, h}));
        repeat (5) @(posedge aclk);
        chk(34'({pause_match_out, tx_pause_hold}), 34'h0);
    endtask

    task automatic drain;
        int k;
        for (k = 0; k < 300 && cq.size() != 0; k++) @(posedge aclk);
    endtask

    initial begin
        void'($urandom(32'h9C24BE5F));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(IDX_CTRL, {RESP_OKAY, 28'h0, CTRL_RESET});
        rd(IDX_TXEN, {RESP_OKAY, 24'h0, TXEN_RESET});
        rd(IDX_SWREQ, {RESP_OKAY, 24'h0, SWREQ_RESET});
        rd(IDX_HOLDOFF, {RESP_OKAY, 16'h0, HOLDOFF_RESET});
        rd(IDX_ADDR_LO, {RESP_OKAY, ADDR_LO_RESET});
        rd(IDX_ADDR_HI, {RESP_OKAY, 16'h0, ADDR_HI_RESET});
        rd(12'h705, {RESP_SLVERR, 32'h0});
        wr(12'h705, 32'h1, RESP_SLVERR);
        a = 48'({$urandom, $urandom}) & 48'hFEFFFFFFFFFF;
        wr(IDX_ADDR_LO, a[31:0], RESP_OKAY);
        wr(IDX_ADDR_HI, {16'h0, a[47:32]}, RESP_OKAY);
        rd(IDX_ADDR_LO, {RESP_OKAY, a[31:0]});
        rd(IDX_ADDR_HI, {RESP_OKAY, 16'h0, a[47:32]});
        s_axi_wstrb <= 4'h2;
        wr(IDX_HOLDOFF, a[31:0], RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(IDX_HOLDOFF, {RESP_OKAY, 16'h0, a[15:8], HOLDOFF_RESET[7:0]});
        rx(a, 16'h0800, OPC_STD, 1'h0, 1'h1, 1'h0, 1'h0);
        rx(a, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h0, 1'h1, 1'h1);
        rx(PAUSE_MCAST, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h0, 1'h1, 1'h1);
        rx(a ^ 48'h1, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h1, 1'h0, 1'h0);
        rx(a, PAUSE_ETHERTYPE, OPC_PFC, 1'h0, 1'h1, 1'h0, 1'h0);
        wr(IDX_CTRL, 32'h7, RESP_OKAY);
        rx(a, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h1, 1'h1, 1'h1);
        rx(a, PAUSE_ETHERTYPE, OPC_STD, 1'h1, 1'h1, 1'h1, 1'h1);
        wr(IDX_CTRL, 32'h3, RESP_OKAY);
        rx(a, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h1, 1'h1, 1'h0);
        wr(IDX_CTRL, 32'h2, RESP_OKAY);
        rx(a, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h0, 1'h0, 1'h0);
        rx(a ^ 48'h1, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h1, 1'h0, 1'h0);
        wr(IDX_CTRL, 32'h5, RESP_OKAY);
        wr(IDX_ADDR_LO, 32'hFFFFFFFF, RESP_OKAY);
        wr(IDX_ADDR_HI, 32'h0000FFFF, RESP_OKAY);
        rx(48'hFFFFFFFFFFFF, PAUSE_ETHERTYPE, OPC_STD, 1'h0, 1'h0, 1'h1, 1'h1);
        @(posedge aclk);
        pause_request_in <= 1'h1;
        cq.push_back(34'h0);
        drain;
        pause_request_in <= 1'h0;
        cq.push_back(34'h8);
        drain;
        cq.push_back(34'h0);
        wr(IDX_SWREQ, 32'h1, RESP_OKAY);
        drain;
        cq.push_back(34'h8);
        wr(IDX_SWREQ, 32'h0, RESP_OKAY);
        drain;
        wr(IDX_TXEN, 32'h0, RESP_OKAY);
        pause_request_in <= 1'h1;
        repeat (20) @(posedge aclk);
        cq.push_back(34'h8);
        pause_request_in <= 1'h0;
        drain;
        wr(IDX_TXEN, 32'hFF, RESP_OKAY);
        wr(IDX_HOLDOFF, 32'h2, RESP_OKAY);
        wr(IDX_CTRL, 32'hD, RESP_OKAY);
        retx = 1'h1;
        pause_request_in <= 1'h1;
        repeat (80) @(posedge aclk);
        chk(34'(n_retx >= 3), 34'h1);
        cq.push_back(34'h8);
        pause_request_in <= 1'h0;
        drain;
        repeat (20) @(posedge aclk);
        close_out;
    end

    // The whole sequence needs a few hundred cycles; this bound of 20000 cycles is well above that.
    initial begin
        #200000;
        n_errors++;
        close_out;
    end
endmodule
`default_nettype wire
